// File: hw/nrf_core_access.sv
// operand access: general-register row, transfer buffer, table load,
// register file with space_read_op/space_write_op, and the system nibbles of the core
// assumes a sequencer issuing one op at a time and waiting on busy;
// program memory answers pm_data combinationally from pm_addr
//
// Contract
// [RULE1] register window is one sixteen-nibble row
// [RULE2] large variant: four pointer bits, two banks
// [RULE3] small variant: three pointer bits, bank zero
// [RULE4] one op reaches any memory or window nibble
// [RULE5] window nibbles share storage with data memory
// [RULE6] transfer buffer sits at 0CH-0FH
// [RULE7] timer count read, modulo write, periods both
// [RULE8] high period bit seven dropped, reads zero
// [RULE9] address pointer uses four nibbles, upper masked
// [RULE10] table load copies program word into buffer
// [RULE11] writes to read-only registers change nothing
// [RULE12] unused peripheral address: undefined read, inert write
// [RULE13] space_read_op/space_write_op 00H-3FH always control registers
// [RULE14] space_read_op/space_write_op 40H-7FH map onto data memory
// [RULE15] sixty-four control addresses, fourteen implemented
// [RULE16] unused control address: undefined read, ignored write
// [RULE17] space_read_op copies register-file nibble to window
// [RULE18] space_write_op copies window to register-file nibble
// [RULE19] system nibbles 74H-7FH ignore the bank
// [RULE20] table load: push, then pop next cycle
// [RULE21] window address is bank, row, column field
`default_nettype none

module nrf_core_access
  import nrf_pkg::*;
#(
  parameter bit TWO_BANKS = 1'b1,
  parameter int ADDR_PTR_BITS = 13,
  parameter logic [63:0] CTRL_USED = 64'h0000_0000_0000_3FFF,
  parameter logic [63:0] CTRL_RO = 64'h0000_0000_0000_0000
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic op_valid,
  input wire nrf_op_e op_code,
  input wire logic [7:0] op_addr,
  input wire logic [3:0] op_col,
  input wire logic [3:0] op_data,
  output logic op_busy,
  output logic op_done,
  output logic [3:0] op_rdata,
  output logic [3:0] window_value,
  output logic [5:0] ctrl_addr,
  output logic ctrl_wstb,
  output logic [3:0] ctrl_wdata,
  input wire logic [3:0] ctrl_rdata,
  output logic [7:0] nrz_low_period_modulo,
  output logic nrz_low_wstb,
  output logic [7:0] nrz_high_period_modulo,
  output logic nrz_high_wstb,
  output logic [7:0] timer_modulo_value,
  output logic timer_modulo_wstb,
  input wire logic [7:0] timer_count_value,
  output logic [15:0] pm_addr,
  input wire logic [15:0] pm_data,
  output logic stack_push,
  output logic stack_pop
);

  localparam int RAM_AW = TWO_BANKS ? 8 : 7;
  localparam logic [15:0] ADDR_MASK = 16'((32'd1 << ADDR_PTR_BITS) - 32'd1);

  ////////////////////////////////////////////////////////////////////////////
  // state

  nrf_state_e state_r;
  nrf_src_e src_r;
  logic [3:0] pend_nib_r;
  logic pend_space_read_op_r;
  logic busy_r;
  logic done_r;
  logic [3:0] rdata_r;
  logic [15:0] dbf_r;
  logic [15:0] addr_ptr_r;
  logic [3:0] wr_r;
  logic bank_r;
  logic [3:0] rp_high_r;
  logic [3:0] rp_low_r;
  logic [5:0] ctrl_addr_r;
  logic ctrl_wstb_r;
  logic [3:0] ctrl_wdata_r;
  logic [7:0] nrz_low_r;
  logic nrz_low_wstb_r;
  logic [7:0] nrz_high_r;
  logic nrz_high_wstb_r;
  logic [7:0] tmr_mod_r;
  logic tmr_mod_wstb_r;
  logic [15:0] pm_addr_r;
  logic push_r;
  logic pop_r;

  nrf_ram_if #(.ADDR_W(RAM_AW)) ram_bus ();

  nrf_data_ram #(.ADDR_W(RAM_AW)) u_ram (
    .mclk (mclk),
    .ram  (ram_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // operand decode

  wire logic take = op_valid && (state_r == ST_IDLE);
  wire logic is_gr = (op_code == OP_GR_RD) || (op_code == OP_GR_WR);
  wire logic is_rf = (op_code == OP_SPACE_READ_OP) || (op_code == OP_SPACE_WRITE_OP);
  wire logic is_rd = (op_code == OP_MEM_RD) || (op_code == OP_GR_RD) || (op_code == OP_SPACE_READ_OP);
  wire logic is_wr = (op_code == OP_MEM_WR) || (op_code == OP_GR_WR) || (op_code == OP_SPACE_WRITE_OP);

  // window row and bank from the pointer
  wire logic [2:0] gr_row = rp_low_r[3:1]; // RULE1
  wire logic gr_bank = TWO_BANKS ? rp_high_r[0] : 1'b0; // RULE2 RULE3

  // effective nibble address
  wire logic [6:0] a7 = is_gr ? {gr_row, op_col} : op_addr[6:0]; // RULE21 RULE4
  wire logic in_shared = (a7 >= SHARED_FIRST); // RULE19
  wire logic want_bank = is_gr ? gr_bank : bank_r;
  wire logic eff_bank = in_shared ? 1'b0 : (want_bank & TWO_BANKS); // RULE19

  // target selection
  wire logic hit_ctrl = is_rf && (a7 <= CTRL_LAST); // RULE13 RULE14
  wire logic [5:0] ctrl_idx = a7[5:0];
  wire logic ctrl_used = CTRL_USED[ctrl_idx]; // RULE15
  wire logic ctrl_ro = CTRL_RO[ctrl_idx];
  wire logic hit_dbf = !hit_ctrl && !eff_bank && (a7 >= DBF_FIRST) && (a7 <= DBF_LAST); // RULE6
  wire logic hit_sys = !hit_ctrl && (a7 >= SYS_FIRST) &&
                       ((a7[3:0] <= SYS_BANK) || (a7[3:0] == SYS_RP_HIGH) ||
                        (a7[3:0] == SYS_RP_LOW));

  // write data: window for space_write_op, operand otherwise
  wire logic [3:0] wdat = (op_code == OP_SPACE_WRITE_OP) ? wr_r : op_data; // RULE18
  wire logic do_wr = take && is_wr && !hit_ctrl;
  wire logic ctrl_wr_ok = take && (op_code == OP_SPACE_WRITE_OP) && hit_ctrl &&
                          ctrl_used && !ctrl_ro; // RULE11 RULE16

  // same storage for window and plain memory ops
  assign ram_bus.addr = RAM_AW'({eff_bank, a7}); // RULE5
  assign ram_bus.we = do_wr && !hit_dbf && !hit_sys;
  assign ram_bus.wdata = wdat;

  ////////////////////////////////////////////////////////////////////////////
  // read-source mux

  wire logic [15:0] ptr_vis = addr_ptr_r & ADDR_MASK; // RULE9
  logic [3:0] sys_nib;
  logic [3:0] dbf_nib;
  logic [3:0] rd_nib;

  // system nibbles held in flops
  always_comb
  begin
    case (pend_nib_r)
      SYS_ADDR3: sys_nib = ptr_vis[15:12];
      SYS_ADDR2: sys_nib = ptr_vis[11:8];
      SYS_ADDR1: sys_nib = ptr_vis[7:4];
      SYS_ADDR0: sys_nib = ptr_vis[3:0];
      SYS_WIN: sys_nib = wr_r;
      SYS_BANK: sys_nib = {3'b000, bank_r};
      SYS_RP_HIGH: sys_nib = rp_high_r;
      SYS_RP_LOW: sys_nib = rp_low_r;
      default: sys_nib = NIB_ZERO;
    endcase
  end

  // buffer nibble 0 holds the low nibble
  always_comb
  begin
    case (pend_nib_r[1:0])
      2'h0: dbf_nib = dbf_r[3:0];
      2'h1: dbf_nib = dbf_r[7:4];
      2'h2: dbf_nib = dbf_r[11:8];
      default: dbf_nib = dbf_r[15:12];
    endcase
  end

  // pick the answer of a pending read
  always_comb
  begin
    case (src_r)
      SRC_RAM: rd_nib = ram_bus.rdata;
      SRC_SYS: rd_nib = sys_nib;
      SRC_DBF: rd_nib = dbf_nib;
      SRC_CTRL: rd_nib = ctrl_rdata;
      default: rd_nib = UNDEF_NIB; // RULE16
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing and read capture

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_r <= ST_IDLE;
      src_r <= SRC_RAM;
      pend_nib_r <= NIB_ZERO;
      pend_space_read_op_r <= 1'b0;
      rdata_r <= NIB_ZERO;
      done_r <= 1'b0;
      busy_r <= 1'b0;
      ctrl_addr_r <= 6'h00;
      pm_addr_r <= ADDR_PTR_RESET;
      push_r <= 1'b0;
      pop_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      push_r <= 1'b0;
      pop_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          if (take && is_rd)
          begin
            state_r <= ST_READ;
            busy_r <= 1'b1;
            pend_nib_r <= a7[3:0];
            pend_space_read_op_r <= (op_code == OP_SPACE_READ_OP);
            ctrl_addr_r <= ctrl_idx;
            if (hit_ctrl)
              src_r <= ctrl_used ? SRC_CTRL : SRC_UNDEF; // RULE13 RULE16
            else if (hit_sys)
              src_r <= SRC_SYS; // RULE19
            else if (hit_dbf)
              src_r <= SRC_DBF;
            else
              src_r <= SRC_RAM; // RULE14
          end
          else if (take && (op_code == OP_TABLE_LOAD_OP))
          begin
            state_r <= ST_TABLE;
            busy_r <= 1'b1;
            pm_addr_r <= ptr_vis; // RULE10
            push_r <= 1'b1; // RULE20
          end
          else if (take && (op_code != OP_NOP))
          begin
            done_r <= 1'b1;
            if (ctrl_wr_ok)
              ctrl_addr_r <= ctrl_idx;
          end
        end
        ST_READ:
        begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
          done_r <= 1'b1;
          if (!pend_space_read_op_r)
            rdata_r <= rd_nib;
        end
        ST_TABLE:
        begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
          done_r <= 1'b1;
          pop_r <= 1'b1; // RULE20
        end
        default:
        begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system nibbles: window, bank, pointer

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      wr_r <= NIB_ZERO;
      bank_r <= 1'b0;
      rp_high_r <= NIB_ZERO;
      rp_low_r <= NIB_ZERO;
    end
    else if (state_r == ST_READ && pend_space_read_op_r)
    begin
      wr_r <= rd_nib; // RULE17
    end
    else if (do_wr && hit_sys)
    begin
      case (a7[3:0])
        SYS_WIN: wr_r <= wdat;
        SYS_BANK: bank_r <= wdat[0] & TWO_BANKS;
        SYS_RP_HIGH: rp_high_r <= TWO_BANKS ? wdat : NIB_ZERO; // RULE2 RULE3
        SYS_RP_LOW: rp_low_r <= wdat;
        default: wr_r <= wr_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address pointer: nibble writes and peripheral transfer

  always_ff @(posedge mclk)
  begin
    if (reset)
      addr_ptr_r <= ADDR_PTR_RESET;
    else if (take && op_code == OP_PUT && op_addr == PA_ADDR_PTR)
      addr_ptr_r <= dbf_r & ADDR_MASK; // RULE9
    else if (do_wr && hit_sys && a7[3:0] == SYS_ADDR3)
      addr_ptr_r[15:12] <= wdat & ADDR_MASK[15:12];
    else if (do_wr && hit_sys && a7[3:0] == SYS_ADDR2)
      addr_ptr_r[11:8] <= wdat & ADDR_MASK[11:8];
    else if (do_wr && hit_sys && a7[3:0] == SYS_ADDR1)
      addr_ptr_r[7:4] <= wdat & ADDR_MASK[7:4];
    else if (do_wr && hit_sys && a7[3:0] == SYS_ADDR0)
      addr_ptr_r[3:0] <= wdat & ADDR_MASK[3:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer buffer: nibble writes, peripheral reads, table load

  always_ff @(posedge mclk)
  begin
    if (reset)
      dbf_r <= DBF_RESET;
    else if (state_r == ST_TABLE)
      dbf_r <= pm_data; // RULE10
    else if (do_wr && hit_dbf)
    begin
      case (a7[1:0])
        2'h0: dbf_r[3:0] <= wdat; // RULE6
        2'h1: dbf_r[7:4] <= wdat;
        2'h2: dbf_r[11:8] <= wdat;
        default: dbf_r[15:12] <= wdat;
      endcase
    end
    else if (take && op_code == OP_GET)
    begin
      case (op_addr)
        PA_NRZ_LOW: dbf_r[7:0] <= nrz_low_r; // RULE7
        PA_NRZ_HIGH: dbf_r[7:0] <= nrz_high_r & HIGH_MOD_MASK; // RULE8
        PA_TMR_COUNT: dbf_r[7:0] <= timer_count_value; // RULE7
        PA_ADDR_PTR: dbf_r <= ptr_vis; // RULE9
        default: dbf_r[7:0] <= UNDEF_BYTE; // RULE12
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral registers loaded from the buffer

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      nrz_low_r <= PERIPH_RESET;
      nrz_high_r <= PERIPH_RESET;
      tmr_mod_r <= PERIPH_RESET;
      nrz_low_wstb_r <= 1'b0;
      nrz_high_wstb_r <= 1'b0;
      tmr_mod_wstb_r <= 1'b0;
    end
    else
    begin
      nrz_low_wstb_r <= 1'b0;
      nrz_high_wstb_r <= 1'b0;
      tmr_mod_wstb_r <= 1'b0;
      if (take && op_code == OP_PUT)
      begin
        case (op_addr)
          PA_NRZ_LOW:
          begin
            nrz_low_r <= dbf_r[7:0]; // RULE7
            nrz_low_wstb_r <= 1'b1;
          end
          PA_NRZ_HIGH:
          begin
            nrz_high_r <= dbf_r[7:0] & HIGH_MOD_MASK; // RULE8
            nrz_high_wstb_r <= 1'b1;
          end
          PA_TMR_MOD:
          begin
            tmr_mod_r <= dbf_r[7:0]; // RULE7
            tmr_mod_wstb_r <= 1'b1;
          end
          default: nrz_low_r <= nrz_low_r; // RULE11 RULE12
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control-register write strobe

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ctrl_wstb_r <= 1'b0;
      ctrl_wdata_r <= NIB_ZERO;
    end
    else
    begin
      ctrl_wstb_r <= ctrl_wr_ok; // RULE18 RULE16
      if (ctrl_wr_ok)
        ctrl_wdata_r <= wr_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign op_busy = busy_r;
  assign op_done = done_r;
  assign op_rdata = rdata_r;
  assign window_value = wr_r;
  assign ctrl_addr = ctrl_addr_r;
  assign ctrl_wstb = ctrl_wstb_r;
  assign ctrl_wdata = ctrl_wdata_r;
  assign nrz_low_period_modulo = nrz_low_r;
  assign nrz_low_wstb = nrz_low_wstb_r;
  assign nrz_high_period_modulo = nrz_high_r;
  assign nrz_high_wstb = nrz_high_wstb_r;
  assign timer_modulo_value = tmr_mod_r;
  assign timer_modulo_wstb = tmr_mod_wstb_r;
  assign pm_addr = pm_addr_r;
  assign stack_push = push_r;
  assign stack_pop = pop_r;

endmodule : nrf_core_access

`default_nettype wire

// File: hw/nrf_pkg.sv
// constants, opcodes and states of the nibble operand-access block
// assumes a 4-bit core whose sequencer issues one operand op at a time
`default_nettype none

package nrf_pkg;

  // data memory geometry
  localparam int NIB_W = 4;
  localparam int ROW_A_W = 7;
  localparam int GR_WORDS = 16;
  localparam int CTRL_REGS = 64;
  localparam int CTRL_USED_N = 14;
  localparam int CTRL_UNUSED_N = 50;

  // data memory map, nibble addresses within a bank
  localparam logic [6:0] DBF_FIRST = 7'h0C;
  localparam logic [6:0] DBF_LAST = 7'h0F;
  localparam logic [6:0] SHARED_FIRST = 7'h70;
  localparam logic [6:0] SYS_FIRST = 7'h74;
  localparam logic [6:0] SYS_LAST = 7'h7F;

  // register-file map
  localparam logic [6:0] CTRL_LAST = 7'h3F;
  localparam logic [6:0] RF_MEM_FIRST = 7'h40;

  // system nibble offsets (low nibble of 7xH)
  localparam logic [3:0] SYS_ADDR3 = 4'h4;
  localparam logic [3:0] SYS_ADDR2 = 4'h5;
  localparam logic [3:0] SYS_ADDR1 = 4'h6;
  localparam logic [3:0] SYS_ADDR0 = 4'h7;
  localparam logic [3:0] SYS_WIN = 4'h8;
  localparam logic [3:0] SYS_BANK = 4'h9;
  localparam logic [3:0] SYS_RP_HIGH = 4'hD;
  localparam logic [3:0] SYS_RP_LOW = 4'hE;

  // peripheral addresses
  localparam logic [7:0] PA_NRZ_LOW = 8'h03;
  localparam logic [7:0] PA_NRZ_HIGH = 8'h04;
  localparam logic [7:0] PA_TMR_COUNT = 8'h05;
  localparam logic [7:0] PA_TMR_MOD = 8'h06;
  localparam logic [7:0] PA_ADDR_PTR = 8'h40;

  // reset values, undefined-read values and the high period mask
  localparam logic [15:0] DBF_RESET = 16'h0320;
  localparam logic [15:0] ADDR_PTR_RESET = 16'h0000;
  localparam logic [7:0] PERIPH_RESET = 8'h00;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] UNDEF_NIB = 4'h0;
  localparam logic [7:0] UNDEF_BYTE = 8'h00;
  localparam logic [7:0] HIGH_MOD_MASK = 8'h7F;

  // operations from the sequencer
  typedef enum logic [3:0] {
    OP_NOP,
    OP_MEM_RD,
    OP_MEM_WR,
    OP_GR_RD,
    OP_GR_WR,
    OP_SPACE_READ_OP,
    OP_SPACE_WRITE_OP,
    OP_PUT,
    OP_GET,
    OP_TABLE_LOAD_OP
  } nrf_op_e;

  // block sequencing
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_TABLE
  } nrf_state_e;

  // read data source latched at request time
  typedef enum logic [2:0] {
    SRC_RAM,
    SRC_SYS,
    SRC_DBF,
    SRC_CTRL,
    SRC_UNDEF
  } nrf_src_e;

endpackage : nrf_pkg

`default_nettype wire

// File: hw/nrf_ram_if.sv
// port bundle between the access logic and the nibble data memory
// assumes one clock shared by both ends
`default_nettype none

interface nrf_ram_if #(parameter int ADDR_W = 8);
  logic [ADDR_W-1:0] addr;
  logic we;
  logic [3:0] wdata;
  logic [3:0] rdata;

  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface : nrf_ram_if

`default_nettype wire

// File: hw/nrf_data_ram.sv
// nibble-wide data memory, both banks, registered read data
// assumes the access logic takes rdata in the cycle after it presents addr
`default_nettype none

module nrf_data_ram
  import nrf_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input wire logic mclk,
  nrf_ram_if.mem ram
);

  logic [3:0] mem_r [0:(1<<ADDR_W)-1];
  logic [3:0] rdata_r;

  // write, then registered read
  always_ff @(posedge mclk)
  begin
    if (ram.we)
    begin
      mem_r[ram.addr] <= ram.wdata;
    end
    rdata_r <= mem_r[ram.addr];
  end

  assign ram.rdata = rdata_r;

endmodule : nrf_data_ram

`default_nettype wire

// File: testbench/nrf_core_access_chk.sv
// concurrent checks on the operand-access block ports
// assumes a bind from the bench top and one clock domain
`default_nettype none

module nrf_core_access_chk
  import nrf_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic op_valid,
  input wire nrf_op_e op_code,
  input wire logic [7:0] op_addr,
  input wire logic op_busy,
  input wire logic op_done,
  input wire logic [3:0] window_value,
  input wire logic [5:0] ctrl_addr,
  input wire logic ctrl_wstb,
  input wire logic [3:0] ctrl_wdata,
  input wire logic [3:0] ctrl_rdata,
  input wire logic nrz_low_wstb,
  input wire logic [7:0] nrz_high_period_modulo,
  input wire logic nrz_high_wstb,
  input wire logic [7:0] timer_modulo_value,
  input wire logic timer_modulo_wstb,
  input wire logic stack_push,
  input wire logic stack_pop
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // request accepted, control index, implemented control nibble, no peripheral strobe
  wire logic take_w = op_valid && !op_busy;
  wire logic [5:0] cidx_w = op_addr[5:0];
  wire logic low_w = op_addr[5:0] < 6'h0E;
  wire logic quiet_w = !nrz_low_wstb && !nrz_high_wstb && !timer_modulo_wstb;

  chk_space_write_op_ctrl: assert property (
    take_w && op_code == OP_SPACE_WRITE_OP && !op_addr[6] && low_w |=> ctrl_wstb && op_done
    && ctrl_wdata == $past(window_value) && ctrl_addr == $past(cidx_w))
    else $error("space_write_op did not reach the control nibble");
  chk_space_write_op_mem: assert property (
    take_w && op_code == OP_SPACE_WRITE_OP && op_addr[6] |=> !ctrl_wstb && op_done)
    else $error("space_write_op above 3FH touched the control space");
  chk_space_read_op_ctrl: assert property (
    take_w && op_code == OP_SPACE_READ_OP && !op_addr[6] && low_w
    |=> ctrl_addr == $past(cidx_w) ##1 window_value == $past(ctrl_rdata))
    else $error("space_read_op did not load the control nibble into the window");
  chk_space_read_op_unused: assert property (
    take_w && op_code == OP_SPACE_READ_OP && !op_addr[6] && !low_w |-> ##2 window_value == UNDEF_NIB)
    else $error("space_read_op of unused control nibble gave another value");
  chk_table_steps: assert property (
    take_w && op_code == OP_TABLE_LOAD_OP |=> stack_push && !stack_pop && op_busy
    ##1 stack_pop && !stack_push && op_done && !op_busy)
    else $error("table load did not push then pop");
  chk_high_bit: assert property (
    nrz_high_period_modulo[7] == 1'b0)
    else $error("high period modulo bit seven set");
  chk_put_modulo: assert property (
    take_w && op_code == OP_PUT && op_addr == PA_TMR_MOD
    |=> timer_modulo_wstb && op_done && !nrz_low_wstb && !nrz_high_wstb)
    else $error("timer modulo write not routed");
  chk_put_inert: assert property (
    take_w && op_code == OP_PUT && (op_addr == PA_TMR_COUNT || op_addr == 8'h07)
    |=> quiet_w && op_done && $stable(timer_modulo_value))
    else $error("write to read-only or unused peripheral changed state");
endmodule : nrf_core_access_chk

`default_nettype wire

// File: testbench/nrf_periph_model.sv
// peripheral side model: control nibbles, program memory, timer count, stack depth
// assumes the block holds ctrl_addr and pm_addr while their read data is used
`default_nettype none

module nrf_periph_model
  import nrf_pkg::*;
#(
  parameter logic [7:0] COUNT_VALUE = 8'hC3,
  parameter logic [15:0] ROM_KEY = 16'h5A3C
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [5:0] ctrl_addr,
  input wire logic ctrl_wstb,
  input wire logic [3:0] ctrl_wdata,
  output logic [3:0] ctrl_rdata,
  input wire logic [15:0] pm_addr,
  output logic [15:0] pm_data,
  output logic [7:0] timer_count_value,
  input wire logic stack_push,
  input wire logic stack_pop,
  output logic [3:0] depth
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] regs_r [0:63];

  // control nibble, program word and timer count answered combinationally
  assign ctrl_rdata = regs_r[ctrl_addr];
  assign pm_data = pm_addr ^ ROM_KEY;
  assign timer_count_value = COUNT_VALUE;

  // control writes stored, stack depth tracked
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      depth <= 4'h0;
      for (int i = 0; i < 64; i++) regs_r[i] <= 4'h0;
    end
    else
    begin
      if (ctrl_wstb) regs_r[ctrl_addr] <= ctrl_wdata;
      depth <= depth + {3'h0, stack_push} - {3'h0, stack_pop};
    end
  end
endmodule : nrf_periph_model

`default_nettype wire

// File: testbench/nrf_core_access_tb.sv
// self-checking bench for the operand-access block
// assumes the peripheral model answers control, program and timer reads
`default_nettype none

module nrf_core_access_tb
  import nrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef enum logic [2:0] {K_NO, K_RD, K_WIN, K_LOW, K_HIGH, K_TMOD, K_PM} nrf_kind_e;
  typedef struct {nrf_op_e op; logic [7:0] a; logic [3:0] c; logic [3:0] d; nrf_kind_e k;
    logic [15:0] e;} nrf_row_s;

  logic mclk, reset, op_valid, op_busy, op_done, ctrl_wstb, stack_push, stack_pop;
  logic nrz_low_wstb, nrz_high_wstb, timer_modulo_wstb;
  nrf_op_e op_code;
  logic [7:0] op_addr, nrz_low_period_modulo, nrz_high_period_modulo, timer_modulo_value;
  logic [7:0] timer_count_value;
  logic [3:0] op_col, op_data, op_rdata, window_value, ctrl_wdata, ctrl_rdata, depth;
  logic [5:0] ctrl_addr;
  logic [15:0] pm_addr, pm_data;
  nrf_row_s rows[$];
  int mismatches = 0;
  int tests_run = 0;

  nrf_core_access #(.ADDR_PTR_BITS(13)) u_nrf_core_access (.mclk, .reset, .op_valid, .op_code,
    .op_addr, .op_col, .op_data, .op_busy, .op_done, .op_rdata, .window_value, .ctrl_addr,
    .ctrl_wstb, .ctrl_wdata, .ctrl_rdata, .nrz_low_period_modulo, .nrz_low_wstb,
    .nrz_high_period_modulo, .nrz_high_wstb, .timer_modulo_value, .timer_modulo_wstb,
    .timer_count_value, .pm_addr, .pm_data, .stack_push, .stack_pop);
  nrf_periph_model u_nrf_periph_model (.mclk, .reset, .ctrl_addr, .ctrl_wstb, .ctrl_wdata,
    .ctrl_rdata, .pm_addr, .pm_data, .timer_count_value, .stack_push, .stack_pop, .depth);

  // 40 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  function automatic void add(nrf_op_e op, logic [7:0] a, logic [3:0] c, logic [3:0] d,
    nrf_kind_e k, logic [15:0] e);
    rows.push_back('{op, a, c, d, k, e});
  endfunction : add

  // result selected by the row's check kind
  function automatic logic [15:0] pick(nrf_kind_e k);
    case (k)
      K_RD: return {12'h000, op_rdata};
      K_WIN: return {12'h000, window_value};
      K_LOW: return {8'h00, nrz_low_period_modulo};
      K_HIGH: return {8'h00, nrz_high_period_modulo};
      K_TMOD: return {8'h00, timer_modulo_value};
      default: return pm_addr;
    endcase
  endfunction : pick

  // one request at a falling edge, then a bounded wait for done
  task automatic do_op(input nrf_op_e c, input logic [7:0] a, input logic [3:0] col,
    input logic [3:0] d);
    int n;
    @(negedge mclk);
    op_valid = 1'b1;
    op_code = c;
    op_addr = a;
    op_col = col;
    op_data = d;
    @(negedge mclk);
    op_valid = 1'b0;
    n = 0;
    while (op_done !== 1'b1 && n < 4)
    begin
      @(negedge mclk);
      n++;
    end
    if (op_done !== 1'b1)
    begin
      mismatches++;
      close_out();
    end
  endtask : do_op

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    op_valid = 1'b0;
    op_code = OP_NOP;
    op_addr = 8'h00;
    op_col = 4'h0;
    op_data = 4'h0;
    add(OP_MEM_WR,8'h25,4'h0,4'hA,K_NO,16'h0);
    add(OP_MEM_WR,8'h7E,4'h0,4'h4,K_NO,16'h0);
    add(OP_GR_RD,8'h00,4'h5,4'h0,K_RD,16'hA);
    add(OP_GR_WR,8'h00,4'h6,4'h9,K_NO,16'h0);
    add(OP_MEM_RD,8'h26,4'h0,4'h0,K_RD,16'h9);
    add(OP_MEM_WR,8'h79,4'h0,4'h1,K_NO,16'h0);
    add(OP_MEM_WR,8'h25,4'h0,4'h3,K_NO,16'h0);
    add(OP_MEM_RD,8'h7E,4'h0,4'h0,K_RD,16'h4);
    add(OP_MEM_WR,8'h79,4'h0,4'h0,K_NO,16'h0);
    add(OP_MEM_RD,8'h25,4'h0,4'h0,K_RD,16'hA);
    add(OP_MEM_WR,8'h7D,4'h0,4'h1,K_NO,16'h0);
    add(OP_GR_RD,8'h00,4'h5,4'h0,K_RD,16'h3);
    add(OP_MEM_WR,8'h7D,4'h0,4'h0,K_NO,16'h0);
    add(OP_MEM_WR,8'h78,4'h0,4'h7,K_NO,16'h0);
    add(OP_MEM_WR,8'h0A,4'h0,4'hB,K_NO,16'h0);
    add(OP_SPACE_WRITE_OP,8'h0A,4'h0,4'h0,K_NO,16'h0);
    add(OP_SPACE_WRITE_OP,8'h45,4'h0,4'h0,K_NO,16'h0);
    add(OP_SPACE_WRITE_OP,8'h20,4'h0,4'h0,K_NO,16'h0);
    add(OP_MEM_WR,8'h78,4'h0,4'h0,K_NO,16'h0);
    add(OP_SPACE_READ_OP,8'h0A,4'h0,4'h0,K_WIN,16'h7);
    add(OP_MEM_RD,8'h0A,4'h0,4'h0,K_RD,16'hB);
    add(OP_MEM_RD,8'h45,4'h0,4'h0,K_RD,16'h7);
    add(OP_SPACE_READ_OP,8'h20,4'h0,4'h0,K_WIN,16'h0);
    add(OP_MEM_WR,8'h0C,4'h0,4'h6,K_NO,16'h0);
    add(OP_MEM_WR,8'h0D,4'h0,4'hF,K_NO,16'h0);
    add(OP_PUT,8'h03,4'h0,4'h0,K_LOW,16'hF6);
    add(OP_PUT,8'h04,4'h0,4'h0,K_HIGH,16'h76);
    add(OP_PUT,8'h06,4'h0,4'h0,K_TMOD,16'hF6);
    add(OP_GET,8'h04,4'h0,4'h0,K_NO,16'h0);
    add(OP_MEM_RD,8'h0D,4'h0,4'h0,K_RD,16'h7);
    add(OP_GET,8'h03,4'h0,4'h0,K_NO,16'h0);
    add(OP_MEM_RD,8'h0D,4'h0,4'h0,K_RD,16'hF);
    add(OP_GET,8'h05,4'h0,4'h0,K_NO,16'h0);
    add(OP_MEM_RD,8'h0D,4'h0,4'h0,K_RD,16'hC);
    add(OP_PUT,8'h05,4'h0,4'h0,K_TMOD,16'hF6);
    add(OP_PUT,8'h07,4'h0,4'h0,K_LOW,16'hF6);
    add(OP_GET,8'h07,4'h0,4'h0,K_NO,16'h0);
    add(OP_MEM_RD,8'h0C,4'h0,4'h0,K_RD,16'h0);
    add(OP_MEM_WR,8'h0C,4'h0,4'h1,K_NO,16'h0);
    add(OP_MEM_WR,8'h0D,4'h0,4'h2,K_NO,16'h0);
    add(OP_MEM_WR,8'h0E,4'h0,4'h3,K_NO,16'h0);
    add(OP_MEM_WR,8'h0F,4'h0,4'hF,K_NO,16'h0);
    add(OP_PUT,8'h40,4'h0,4'h0,K_NO,16'h0);
    add(OP_MEM_RD,8'h74,4'h0,4'h0,K_RD,16'h1);
    add(OP_MEM_WR,8'h0F,4'h0,4'h0,K_NO,16'h0);
    add(OP_GET,8'h40,4'h0,4'h0,K_NO,16'h0);
    add(OP_MEM_RD,8'h0F,4'h0,4'h1,K_RD,16'h1);
    // 13-bit pointer 1321H fetches 1321H xor 5A3CH = 491DH
    add(OP_TABLE_LOAD_OP,8'h00,4'h0,4'h0,K_PM,16'h1321);
    add(OP_MEM_RD,8'h0C,4'h0,4'h0,K_RD,16'hD);
    add(OP_MEM_RD,8'h0F,4'h0,4'h0,K_RD,16'h4);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    reset = 1'b0;
    foreach (rows[i])
    begin
      do_op(rows[i].op, rows[i].a, rows[i].c, rows[i].d);
      if (rows[i].k != K_NO) chk(pick(rows[i].k), rows[i].e);
    end
    // a write offered while a read is busy is dropped
    @(negedge mclk);
    op_valid = 1'b1;
    op_code = OP_MEM_RD;
    op_addr = 8'h25;
    @(negedge mclk);
    op_code = OP_MEM_WR;
    op_data = 4'h0;
    @(negedge mclk);
    op_valid = 1'b0;
    chk(op_rdata, 16'hA);
    do_op(OP_MEM_RD, 8'h25, 4'h0, 4'h0);
    chk(op_rdata, 16'hA);
    chk(depth, 16'h0);
    do_op(OP_MEM_WR, 8'h78, 4'h0, 4'h5);
    // second reset in mid-run
    @(negedge mclk);
    reset = 1'b1;
    @(negedge mclk);
    reset = 1'b0;
    chk(window_value, 16'h0);
    chk(pm_addr, 16'h0);
    chk(nrz_low_period_modulo, 16'h0);
    do_op(OP_MEM_RD, 8'h0D, 4'h0, 4'h0);
    chk(op_rdata, 16'h2);
    do_op(OP_MEM_RD, 8'h0E, 4'h0, 4'h0);
    chk(op_rdata, 16'h3);
    close_out();
  end
endmodule : nrf_core_access_tb

bind nrf_core_access nrf_core_access_chk u_nrf_core_access_chk (.mclk, .reset, .op_valid,
  .op_code, .op_addr, .op_busy, .op_done, .window_value, .ctrl_addr, .ctrl_wstb, .ctrl_wdata,
  .ctrl_rdata, .nrz_low_wstb, .nrz_high_period_modulo, .nrz_high_wstb, .timer_modulo_value,
  .timer_modulo_wstb, .stack_push, .stack_pop);

`default_nettype wire
